// ---- core/sbf_top.sv ----
// buffered serial port: APB registers, event flags, data port mapping
// assumes an APB master on clock_in and asynchronous serial pins
`timescale 1ns/1ps
`default_nettype none

module sbf_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic              clock_in,
    input  wire logic              rst_in,
    input  wire logic              ce_in,
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [ADDR_W-1:0] paddr_in,
    input  wire logic [31:0]       pwdata_in,
    output logic      [31:0]       prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    input  wire logic              sck_in,
    input  wire logic              sdi_in,
    input  wire logic              ss_n_in,
    output logic                   sck_out,
    output logic                   sck_oe_n_out,
    output logic                   sdo_out,
    output logic                   sdo_oe_n_out,
    output logic                   irq_out
);
    sbf_shift_if sif ();

    // register state
    logic [7:0]  ctrl_r, ctrl_nxt;
    logic [7:0]  mask_r, mask_nxt;
    logic [7:0]  txb_r, txb_nxt;
    logic        txv_r, txv_nxt;
    logic [7:0]  rxb_r, rxb_nxt;
    logic [7:0]  rxd_r, rxd_nxt;
    logic [1:0]  cnt_r, cnt_nxt;
    logic        rxc_r, rxc_nxt;
    logic        txc_r, txc_nxt;
    logic        ssf_r, ssf_nxt;
    logic        ovf_r, ovf_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic        perr_r, perr_nxt;
    logic        ss_s1_r, ss_s2_r;

    // decoded strobes and helpers
    logic        setup, access, wr, rd;
    logic        wr_ctrl, wr_mask, wr_flags, wr_data, rd_data, rd_flags;
    logic        bufmode, host, enable, selign;
    logic        takeover;
    logic [1:0]  cnt_mid;
    logic [7:0]  flags_v;
    logic [7:0]  w1c;

    // one decode used by both the read mux and the write strobes
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        hit = (a == ADDR_W'(off));
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = hit(a, sbf_pkg::ADDR_CTRL) || hit(a, sbf_pkg::ADDR_DATA) ||
                 hit(a, sbf_pkg::ADDR_MASK) || hit(a, sbf_pkg::ADDR_FLAGS);
    endfunction

    // apb phases; every access finishes with no wait state
    assign setup    = psel_in && !penable_in;
    assign access   = psel_in && penable_in;
    assign wr       = access && pwrite_in;
    assign rd       = access && !pwrite_in;
    assign wr_ctrl  = wr && hit(paddr_in, sbf_pkg::ADDR_CTRL);
    assign wr_mask  = wr && hit(paddr_in, sbf_pkg::ADDR_MASK);
    assign wr_flags = wr && hit(paddr_in, sbf_pkg::ADDR_FLAGS);
    assign wr_data  = wr && hit(paddr_in, sbf_pkg::ADDR_DATA);
    assign rd_data  = rd && hit(paddr_in, sbf_pkg::ADDR_DATA);
    assign rd_flags = rd && hit(paddr_in, sbf_pkg::ADDR_FLAGS);

    assign bufmode  = ctrl_r[sbf_pkg::CTRL_BUFMODE];
    assign host     = ctrl_r[sbf_pkg::CTRL_HOST];
    assign enable   = ctrl_r[sbf_pkg::CTRL_ENABLE];
    assign selign   = ctrl_r[sbf_pkg::CTRL_SELIGN];

    // takeover looks only at the second synchroniser stage
    assign takeover = enable && host && !selign && !ss_s2_r;

    // flag view; the empty flag is a live view of the transmit stage
    always_comb begin
        flags_v = 8'h00;
        flags_v[sbf_pkg::FLAG_RXC] = rxc_r;
        flags_v[sbf_pkg::FLAG_TXC] = txc_r;
        flags_v[sbf_pkg::FLAG_DRE] = !txv_r;
        flags_v[sbf_pkg::FLAG_SS]  = ssf_r;
        flags_v[sbf_pkg::FLAG_OVF] = ovf_r;
    end

    // write-one-to-clear mask from the flag register
    assign w1c = wr_flags ? (pwdata_in[7:0] & sbf_pkg::FLAG_WMASK) : 8'h00;

    // control, mask and role handling
    always_comb begin
        ctrl_nxt = ctrl_r;
        mask_nxt = mask_r;
        if (wr_ctrl) begin
            ctrl_nxt = pwdata_in[7:0] & sbf_pkg::CTRL_WMASK;
        end
        if (wr_mask) begin
            mask_nxt = pwdata_in[7:0] & sbf_pkg::FLAG_WMASK;
        end
        // hardware drop of host mode outranks a same-cycle software write
        if (takeover) begin
            ctrl_nxt[sbf_pkg::CTRL_HOST] = 1'b0;
        end
    end

    // transmit side: one stage in either mode
    always_comb begin
        txb_nxt = txb_r;
        txv_nxt = txv_r;
        txc_nxt = txc_r;
        ssf_nxt = ssf_r;
        // engine took the staged byte
        if (sif.begin_evt) begin
            txv_nxt = 1'b0;
        end
        // both modes load the written byte into the one tx stage;
        // a write after the begin pulse wins so the new byte is kept
        if (wr_data) begin
            txb_nxt = pwdata_in[7:0];
            txv_nxt = 1'b1;
        end
        // flag read clears the tx-complete and select events it actually returned
        if (rd_flags) begin
            txc_nxt = txc_r & !prdata_r[sbf_pkg::FLAG_TXC];
            ssf_nxt = ssf_r & !prdata_r[sbf_pkg::FLAG_SS];
        end
        if (w1c[sbf_pkg::FLAG_TXC]) begin
            txc_nxt = 1'b0;
        end
        if (w1c[sbf_pkg::FLAG_SS]) begin
            ssf_nxt = 1'b0;
        end
        // sets come last so an event beats a clear in the same cycle
        if (sif.done_evt && !txv_r) begin
            txc_nxt = 1'b1;
        end
        if (takeover) begin
            ssf_nxt = 1'b1;
        end
    end

    // receive side: count of unread bytes after a read, then the arrival
    always_comb begin
        rxb_nxt = rxb_r;
        rxd_nxt = rxd_r;
        cnt_nxt = cnt_r;
        rxc_nxt = rxc_r;
        ovf_nxt = ovf_r;
        cnt_mid = cnt_r;
        if (bufmode) begin
            // a read hands out the front entry and pulls the second forward
            if (rd_data && (cnt_r != 2'd0)) begin
                rxb_nxt = rxd_r;
                cnt_mid = cnt_r - 2'd1;
            end
            cnt_nxt = cnt_mid;
            if (sif.done_evt) begin
                // arrival only follows a begun frame, so no early overrun
                case (cnt_mid)
                    2'd0: begin
                        rxb_nxt = sif.rx_byte;
                        cnt_nxt = 2'd1;
                    end
                    2'd1: begin
                        rxd_nxt = sif.rx_byte;
                        cnt_nxt = 2'd2;
                    end
                    default: begin
                        cnt_nxt = cnt_mid; // third byte is dropped
                    end
                endcase
            end
            if (rd_data && (cnt_mid == 2'd0)) begin
                rxc_nxt = 1'b0;
            end
        end else begin
            cnt_nxt = 2'd0;
            if (sif.done_evt) begin
                rxd_nxt = sif.rx_byte;
            end
            if (rd_data) begin
                rxc_nxt = 1'b0;
            end
        end
        if (rd_data) begin
            ovf_nxt = 1'b0;
        end
        if (w1c[sbf_pkg::FLAG_RXC]) begin
            rxc_nxt = 1'b0;
        end
        if (w1c[sbf_pkg::FLAG_OVF]) begin
            ovf_nxt = 1'b0;
        end
        // sets last: set wins over clear
        if (sif.done_evt) begin
            rxc_nxt = 1'b1;
        end
        if (sif.done_evt && bufmode && (cnt_mid == 2'(sbf_pkg::RX_DEPTH))) begin
            ovf_nxt = 1'b1;
        end
    end

    // read data is latched in the setup phase, so side effects at the
    // access edge can only clear what the master is really handed
    always_comb begin
        prdata_nxt = prdata_r;
        perr_nxt   = perr_r;
        if (setup) begin
            prdata_nxt = 32'h0000_0000;
            perr_nxt   = !mapped(paddr_in);
            if (hit(paddr_in, sbf_pkg::ADDR_CTRL)) begin
                prdata_nxt[7:0] = ctrl_r;
            end
            if (hit(paddr_in, sbf_pkg::ADDR_MASK)) begin
                prdata_nxt[7:0] = mask_r;
            end
            if (hit(paddr_in, sbf_pkg::ADDR_FLAGS)) begin
                prdata_nxt[7:0] = flags_v;
            end
            if (hit(paddr_in, sbf_pkg::ADDR_DATA)) begin
                prdata_nxt[7:0] = bufmode ? rxb_r : rxd_r;
            end
        end
    end

    // all registers of this module; clock enable freezes everything
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            ctrl_r   <= sbf_pkg::CTRL_RST;
            mask_r   <= sbf_pkg::MASK_RST;
            txb_r    <= sbf_pkg::DATA_RST;
            txv_r    <= 1'b0;
            rxb_r    <= sbf_pkg::DATA_RST;
            rxd_r    <= sbf_pkg::DATA_RST;
            cnt_r    <= 2'd0;
            rxc_r    <= 1'b0;
            txc_r    <= 1'b0;
            ssf_r    <= 1'b0;
            ovf_r    <= 1'b0;
            prdata_r <= 32'h0000_0000;
            perr_r   <= 1'b0;
            ss_s1_r  <= 1'b1;
            ss_s2_r  <= 1'b1;
        end else if (ce_in) begin
            ctrl_r   <= ctrl_nxt;
            mask_r   <= mask_nxt;
            txb_r    <= txb_nxt;
            txv_r    <= txv_nxt;
            rxb_r    <= rxb_nxt;
            rxd_r    <= rxd_nxt;
            cnt_r    <= cnt_nxt;
            rxc_r    <= rxc_nxt;
            txc_r    <= txc_nxt;
            ssf_r    <= ssf_nxt;
            ovf_r    <= ovf_nxt;
            prdata_r <= prdata_nxt;
            perr_r   <= perr_nxt;
            ss_s1_r  <= ss_n_in;
            ss_s2_r  <= ss_s1_r;
        end
    end

    // engine control: host starts while a byte is staged and the engine
    // is idle; in client role the staged byte waits for the remote host
    assign sif.enable    = enable;
    assign sif.host_mode = host;
    assign sif.start     = host && txv_r && !sif.busy && !sif.begin_evt;
    assign sif.tx_byte   = txb_r;
    assign sif.ss_active = enable && !host && !ss_s2_r;

    sbf_shifter u_shifter (
        .clock_in     (clock_in),
        .rst_in       (rst_in),
        .ce_in        (ce_in),
        .sck_in       (sck_in),
        .sdi_in       (sdi_in),
        .sck_out      (sck_out),
        .sck_oe_n_out (sck_oe_n_out),
        .sdo_out      (sdo_out),
        .sdo_oe_n_out (sdo_oe_n_out),
        .sif          (sif)
    );

    // apb answers; the level interrupt stays up as long as an enabled flag does
    assign prdata_out  = prdata_r;
    assign pslverr_out = access && perr_r;
    assign pready_out  = access;
    assign irq_out     = |(flags_v & mask_r);
endmodule

`default_nettype wire

// ---- core/sbf_pkg.sv ----
// constants and types shared by the buffered serial port core
// assumes a single 100 MHz peripheral clock with synchronous reset
package sbf_pkg;

    // register byte offsets on the APB
    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_DATA  = 8'h04;
    localparam logic [7:0] ADDR_MASK  = 8'h08;
    localparam logic [7:0] ADDR_FLAGS = 8'h0C;

    // control register field positions
    localparam int CTRL_ENABLE  = 0;
    localparam int CTRL_SELIGN  = 2;
    localparam int CTRL_HOST    = 5;
    localparam int CTRL_BUFMODE = 7;
    localparam logic [7:0] CTRL_WMASK = 8'hA5;

    // event flag positions, shared by the mask register
    localparam int FLAG_RXC = 7;
    localparam int FLAG_TXC = 6;
    localparam int FLAG_DRE = 5;
    localparam int FLAG_SS  = 4;
    localparam int FLAG_OVF = 0;
    localparam logic [7:0] FLAG_WMASK = 8'hF1;

    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;

    // timing: generated serial clock half period
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCK_HALF_NS   = 80;
    localparam int SCK_HALF_CYC  = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // serial frame and receive depth
    localparam int FRAME_BITS = 8;
    localparam int RX_DEPTH   = 2;

    typedef enum logic {
        SBF_IDLE,
        SBF_RUN
    } sbf_eng_state_t;

endpackage

// ---- core/sbf_shift_if.sv ----
// bundle between the register side and the serial shift engine
// assumes both ends run on the same peripheral clock
`timescale 1ns/1ps
`default_nettype none

interface sbf_shift_if;
    logic       enable;
    logic       host_mode;
    logic       start;
    logic [7:0] tx_byte;
    logic       ss_active;
    logic       begin_evt;
    logic       done_evt;
    logic       busy;
    logic [7:0] rx_byte;

    modport ctl (output enable, host_mode, start, tx_byte, ss_active,
                 input  begin_evt, done_evt, busy, rx_byte);
    modport eng (input  enable, host_mode, start, tx_byte, ss_active,
                 output begin_evt, done_evt, busy, rx_byte);
endinterface

`default_nettype wire

// ---- core/sbf_shifter.sv ----
// serial shift engine, mode 0, msb first, host or client
// assumes sck and data-in pins are asynchronous and are synchronised here
`timescale 1ns/1ps
`default_nettype none

module sbf_shifter (
    input  wire logic  clock_in,
    input  wire logic  rst_in,
    input  wire logic  ce_in,
    input  wire logic  sck_in,
    input  wire logic  sdi_in,
    output logic       sck_out,
    output logic       sck_oe_n_out,
    output logic       sdo_out,
    output logic       sdo_oe_n_out,
    sbf_shift_if.eng   sif
);
    localparam logic [7:0] HALF_LAST = 8'(sbf_pkg::SCK_HALF_CYC - 1);
    localparam logic [3:0] LAST_BIT  = 4'(sbf_pkg::FRAME_BITS);

    sbf_pkg::sbf_eng_state_t state_r, state_nxt;
    logic       sck_s1_r, sck_s2_r, sck_s3_r;
    logic       sdi_s1_r, sdi_s2_r;
    logic [7:0] sh_r, sh_nxt;
    logic [7:0] rx_r, rx_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] div_r, div_nxt;
    logic       sck_r, sck_nxt;
    logic       samp_r, samp_nxt;
    logic       begin_r, begin_nxt;
    logic       done_r, done_nxt;
    logic       rise, fall;

    // client edges from the synchronised pin, never the first stage; host edges from the divider
    always_comb begin
        rise = 1'b0;
        fall = 1'b0;
        if (sif.host_mode) begin
            rise = (div_r == HALF_LAST) && !sck_r;
            fall = (div_r == HALF_LAST) && sck_r;
        end else begin
            rise = sck_s2_r && !sck_s3_r;
            fall = !sck_s2_r && sck_s3_r;
        end
    end

    // next state of the engine
    always_comb begin
        state_nxt = state_r;
        sh_nxt    = sh_r;
        rx_nxt    = rx_r;
        cnt_nxt   = cnt_r;
        div_nxt   = div_r;
        sck_nxt   = sck_r;
        samp_nxt  = samp_r;
        begin_nxt = 1'b0;
        done_nxt  = 1'b0;
        case (state_r)
            sbf_pkg::SBF_IDLE: begin
                sck_nxt = 1'b0;
                div_nxt = 8'h00;
                cnt_nxt = 4'h0;
                // host starts on a software write, client on select
                if (sif.enable && ((sif.host_mode && sif.start) ||
                                   (!sif.host_mode && sif.ss_active))) begin
                    sh_nxt    = sif.tx_byte;
                    begin_nxt = 1'b1;
                    state_nxt = sbf_pkg::SBF_RUN;
                end
            end
            sbf_pkg::SBF_RUN: begin
                if (sif.host_mode) begin
                    div_nxt = (div_r == HALF_LAST) ? 8'h00 : div_r + 8'h01;
                    if (div_r == HALF_LAST) begin
                        sck_nxt = !sck_r;
                    end
                end
                if (rise) begin
                    samp_nxt = sdi_s2_r;
                    cnt_nxt  = cnt_r + 4'h1;
                end
                if (fall) begin
                    sh_nxt = {sh_r[6:0], samp_r};
                    if (cnt_r == LAST_BIT) begin
                        rx_nxt    = {sh_r[6:0], samp_r};
                        done_nxt  = 1'b1;
                        state_nxt = sbf_pkg::SBF_IDLE;
                    end
                end
                // lost enable, or lost select in client role, aborts the frame
                if (!sif.enable || (!sif.host_mode && !sif.ss_active)) begin
                    state_nxt = sbf_pkg::SBF_IDLE;
                    done_nxt  = 1'b0;
                end
            end
            default: begin
                state_nxt = sbf_pkg::SBF_IDLE;
            end
        endcase
    end

    // registers, frozen while the clock enable is low
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_r  <= sbf_pkg::SBF_IDLE;
            sck_s1_r <= 1'b0;
            sck_s2_r <= 1'b0;
            sck_s3_r <= 1'b0;
            sdi_s1_r <= 1'b0;
            sdi_s2_r <= 1'b0;
            sh_r     <= sbf_pkg::DATA_RST;
            rx_r     <= sbf_pkg::DATA_RST;
            cnt_r    <= 4'h0;
            div_r    <= 8'h00;
            sck_r    <= 1'b0;
            samp_r   <= 1'b0;
            begin_r  <= 1'b0;
            done_r   <= 1'b0;
        end else if (ce_in) begin
            state_r  <= state_nxt;
            sck_s1_r <= sck_in;
            sck_s2_r <= sck_s1_r;
            sck_s3_r <= sck_s2_r;
            sdi_s1_r <= sdi_in;
            sdi_s2_r <= sdi_s1_r;
            sh_r     <= sh_nxt;
            rx_r     <= rx_nxt;
            cnt_r    <= cnt_nxt;
            div_r    <= div_nxt;
            sck_r    <= sck_nxt;
            samp_r   <= samp_nxt;
            begin_r  <= begin_nxt;
            done_r   <= done_nxt;
        end
    end

    assign sif.begin_evt = begin_r;
    assign sif.done_evt  = done_r;
    assign sif.busy      = (state_r == sbf_pkg::SBF_RUN);
    assign sif.rx_byte   = rx_r;
    assign sck_out       = sck_r;
    assign sdo_out       = sh_r[7];
    // enables are active low: drive only in the matching role
    assign sck_oe_n_out  = !(sif.enable && sif.host_mode);
    assign sdo_oe_n_out  = !(sif.enable && (sif.host_mode || sif.ss_active));
endmodule

`default_nettype wire

// ---- dv/sbf_chk.sv ----
// pin-level checker for the buffered serial port top
// assumes APB on clock_in; bound to every sbf_top instance
`timescale 1ns/1ps
`default_nettype none

module sbf_chk #(
    parameter int ADDR_W = 8
) (
    input wire logic              clock_in,
    input wire logic              rst_in,
    input wire logic              psel_in,
    input wire logic              penable_in,
    input wire logic              pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0]       pwdata_in,
    input wire logic [31:0]       prdata_out,
    input wire logic              pready_out,
    input wire logic              pslverr_out,
    input wire logic              ss_n_in,
    input wire logic              sck_oe_n_out,
    input wire logic              irq_out
);
    logic [7:0] ctl_r, ctl_nxt, msk_r, msk_nxt;
    logic       acc, mapped, host_sh;

    // access phase and address decode seen from the pins
    assign acc = psel_in && penable_in;
    assign mapped = paddr_in inside {ADDR_W'(sbf_pkg::ADDR_CTRL), ADDR_W'(sbf_pkg::ADDR_DATA),
                                     ADDR_W'(sbf_pkg::ADDR_MASK), ADDR_W'(sbf_pkg::ADDR_FLAGS)};
    assign host_sh = ctl_r[sbf_pkg::CTRL_ENABLE] && ctl_r[sbf_pkg::CTRL_HOST];

    // shadow of what software wrote; the hardware clear of host is not tracked
    always_comb begin
        ctl_nxt = ctl_r;
        msk_nxt = msk_r;
        if (acc && pwrite_in && paddr_in == ADDR_W'(sbf_pkg::ADDR_CTRL)) ctl_nxt = pwdata_in[7:0];
        if (acc && pwrite_in && paddr_in == ADDR_W'(sbf_pkg::ADDR_MASK)) msk_nxt = pwdata_in[7:0];
    end

    always_ff @(posedge clock_in) begin
        ctl_r <= rst_in ? 8'h00 : ctl_nxt;
        msk_r <= rst_in ? 8'h00 : msk_nxt;
    end

    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);

    a_ready_zero_wait: assert property (acc |-> pready_out)
        else $error("pready missing in access phase");
    a_err_unmapped: assert property (acc && !mapped |-> pslverr_out)
        else $error("unmapped access without pslverr");
    a_err_access_only: assert property (pslverr_out |-> acc && !mapped)
        else $error("pslverr outside an unmapped access");
    a_rdata_upper_zero: assert property (pready_out |-> prdata_out[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_irq_follows_flags: assert property (acc && !pwrite_in
        && paddr_in == ADDR_W'(sbf_pkg::ADDR_FLAGS) && |(prdata_out[7:0] & msk_r) |-> irq_out)
        else $error("enabled flag set but irq low");
    a_irq_masked_off: assert property ((msk_r == 8'h00) [*2] |-> !irq_out)
        else $error("irq high with all enables off");
    a_takeover_drop: assert property ((!ss_n_in) [*2] ##0
        (host_sh && !ctl_r[sbf_pkg::CTRL_SELIGN] && !sck_oe_n_out) |-> ##[1:6] sck_oe_n_out)
        else $error("host role kept after select low");
    a_selign_hold: assert property ((host_sh && ctl_r[sbf_pkg::CTRL_SELIGN]) [*3]
        |-> !sck_oe_n_out)
        else $error("host role lost while select ignored");
endmodule

bind sbf_top sbf_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

`default_nettype wire

// ---- dv/sbf_peer.sv ----
// behavioural far-side serial device, mode 0, msb first
// assumes sck_in is the resolved clock line and mosi_in the block's data out
`timescale 1ns/1ps
`default_nettype none

module sbf_peer (
    input  wire logic sck_in,
    input  wire logic mosi_in,
    output logic      sck_out,
    output logic      ss_n_out,
    output logic      sdo_out
);
    logic [7:0] rep, os, sh, hs;
    logic [7:0] got [$];
    int         cnt;
    bit         hosting;

    initial begin
        sck_out = 1'b0;
        ss_n_out = 1'b1;
    end

    // data line follows whichever role the model plays
    assign sdo_out = hosting ? hs[7] : os[7];

    // client role: sample on rising clock, collect whole bytes
    always @(posedge sck_in) begin
        if (!hosting) begin
            sh = {sh[6:0], mosi_in};
            cnt++;
            if (cnt == 8) begin
                got.push_back(sh);
                cnt = 0;
            end
        end
    end

    // client role: shift on falling clock, next reply is one higher
    always @(negedge sck_in) begin
        if (!hosting) begin
            if (cnt == 0) begin
                rep++;
                os = rep;
            end else begin
                os = os << 1;
            end
        end
    end

    task automatic load(input logic [7:0] b);
        rep = b;
        os = b;
        cnt = 0;
        got.delete();
    endtask

    // select pulse with the clock standing still
    task automatic sel();
        ss_n_out <= 1'b0;
        #400;
        ss_n_out = 1'b1;
        #400;
    endtask

    // host role frame, 160 ns clock period, odd start offset to stay off the bus clock
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        hosting = 1'b1;
        hs = tx;
        ss_n_out <= 1'b0;
        #323;
        repeat (8) begin
            sck_out = 1'b1;
            rx = {rx[6:0], mosi_in};
            #80;
            sck_out = 1'b0;
            hs = hs << 1;
            #80;
        end
        ss_n_out = 1'b1;
        hosting = 1'b0;
        #200;
    endtask
endmodule

`default_nettype wire

// ---- dv/spi_buffered_flags_and_data_port_test.sv ----
// self-checking bench for the buffered serial port
// assumes sbf_peer as far side and the bound pin checker
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end

module spi_buffered_flags_and_data_port_test;
    logic        clock_in, rst_in, ce_in, psel_in, penable_in, pwrite_in;
    logic [7:0]  paddr_in, prx;
    logic [31:0] pwdata_in, prdata_out, rdv;
    logic        pready_out, pslverr_out, erv, irq_out;
    logic        sck_out, sck_oe_n_out, sdo_out, sdo_oe_n_out, p_sck, p_ss_n, p_sdo, sck_w;
    int          fail_count = 0;
    int          total_checks = 0;
    localparam logic [7:0] AC = sbf_pkg::ADDR_CTRL, AD = sbf_pkg::ADDR_DATA;
    localparam logic [7:0] AM = sbf_pkg::ADDR_MASK, AF = sbf_pkg::ADDR_FLAGS;
    // reset image: address, then slave error and low byte of read data
    logic [16:0] rows [5] = '{{sbf_pkg::ADDR_CTRL, 1'b0, sbf_pkg::CTRL_RST},
        {sbf_pkg::ADDR_DATA, 1'b0, sbf_pkg::DATA_RST}, {sbf_pkg::ADDR_MASK, 1'b0, sbf_pkg::MASK_RST},
        {sbf_pkg::ADDR_FLAGS, 1'b0, 8'h20}, {8'h10, 1'b1, 8'h00}};

    // clock line: block drives while enabled low, else the far side
    assign sck_w = sck_oe_n_out ? p_sck : sck_out;

    sbf_top dut (.*, .sck_in(sck_w), .sdi_in(p_sdo), .ss_n_in(p_ss_n));

    sbf_peer peer (.sck_in(sck_w), .mosi_in(sdo_out), .sck_out(p_sck), .ss_n_out(p_ss_n),
        .sdo_out(p_sdo));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // one APB transfer; leaves read data and error in rdv and erv
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge clock_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= {24'h000000, d};
        @(posedge clock_in);
        penable_in <= 1'b1;
        @(posedge clock_in);
        while (pready_out !== 1'b1 && n < 20) begin
            @(posedge clock_in);
            n++;
        end
        if (n == 20) fail_count++;
        rdv = prdata_out;
        erv = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    // bounded wait for the interrupt line
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq_out !== 1'b1 && n < 3000) begin
            @(posedge clock_in);
            n++;
        end
    endtask

    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    // watchdog well beyond the longest sequence
    initial begin
        #500000;
        fail_count++;
        finish_test();
    end

    initial begin
        {rst_in, ce_in, psel_in, penable_in, pwrite_in} = 5'h18;
        paddr_in = 8'h00;
        pwdata_in = 32'h00000000;
        repeat (10) @(posedge clock_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, rows[i][16:9], 8'h00);
            `CHK({erv, rdv[7:0]}, rows[i][8:0])
        end
        // buffer mode host: enable, select ignore, host, buffers
        peer.load(8'h3C);
        apb(1'b1, AC, 8'hA5);
        apb(1'b1, AM, 8'h40);
        apb(1'b1, AD, 8'h81);
        repeat (5) @(posedge clock_in);
        apb(1'b1, AD, 8'h42);
        apb(1'b0, AF, 8'h00);
        `CHK(rdv[5], 1'b0)
        wait_irq();
        `CHK(irq_out, 1'b1)
        apb(1'b0, AF, 8'h00);
        `CHK(rdv[7:0], 8'hE0)
        @(negedge clock_in);
        `CHK(irq_out, 1'b0)
        apb(1'b0, AD, 8'h00);
        `CHK(rdv[7:0], 8'h3C)
        apb(1'b0, AD, 8'h00);
        `CHK(rdv[7:0], 8'h3D)
        apb(1'b0, AF, 8'h00);
        `CHK(rdv[7:0], 8'h20)
        `CHK(peer.got[0], 8'h81)
        `CHK(peer.got[1], 8'h42)
        // three bytes in with nothing read: third is lost
        apb(1'b1, AD, 8'h11);
        repeat (5) @(posedge clock_in);
        apb(1'b1, AD, 8'h22);
        repeat (140) @(posedge clock_in);
        apb(1'b1, AD, 8'h33);
        wait_irq();
        apb(1'b0, AF, 8'h00);
        `CHK(rdv[7:0], 8'hE1)
        apb(1'b1, AM, 8'h80);
        @(negedge clock_in);
        `CHK(irq_out, 1'b1)
        apb(1'b1, AF, 8'h81);
        @(negedge clock_in);
        `CHK(irq_out, 1'b0)
        apb(1'b0, AF, 8'h00);
        `CHK(rdv[0], 1'b0)
        apb(1'b0, AD, 8'h00);
        `CHK(rdv[7:0], 8'h3E)
        apb(1'b0, AD, 8'h00);
        `CHK(rdv[7:0], 8'h3F)
        // select taken low from outside, first honoured then ignored
        apb(1'b1, AC, 8'h21);
        peer.sel();
        apb(1'b0, AF, 8'h00);
        `CHK(rdv[4], 1'b1)
        apb(1'b0, AC, 8'h00);
        `CHK(rdv[7:0], 8'h01)
        apb(1'b1, AC, 8'h25);
        peer.sel();
        apb(1'b0, AF, 8'h00);
        `CHK(rdv[4], 1'b0)
        apb(1'b0, AC, 8'h00);
        `CHK(rdv[7:0], 8'h25)
        // client, normal mode: write only stages, far side clocks it out
        apb(1'b1, AC, 8'h01);
        apb(1'b1, AD, 8'h5A);
        peer.xfer(8'h96, prx);
        `CHK(prx, 8'h5A)
        apb(1'b0, AD, 8'h00);
        `CHK(rdv[7:0], 8'h96)
        finish_test();
    end
endmodule

`default_nettype wire
